//--- include/rpsel_consts.vh
// Purpose: constants for the remappable input pin select block
// Assumes: 16-bit register words, 5-bit selection fields
// Notes:   offsets of the register port are chosen locally
`ifndef RPSEL_CONSTS_VH
`define RPSEL_CONSTS_VH

`define RPSEL_AW            4
`define RPSEL_DW            16
`define RPSEL_SELW          5
`define RPSEL_NPIN          26
// register port offsets
`define RPSEL_OFF_IRQ1      4'h0
`define RPSEL_OFF_IRQ2      4'h1
`define RPSEL_OFF_TMR       4'h3
`define RPSEL_OFF_OSC       4'h8
`define RPSEL_OFF_OUTMAP0   4'h9
`define RPSEL_OFF_OUTMAP1   4'hA
// field positions
`define RPSEL_HI_LSB        8
`define RPSEL_LO_LSB        0
`define RPSEL_LOCK_BIT      6
// selection codes
`define RPSEL_SEL_RST       5'h00
`define RPSEL_SEL_MAXPIN    5'h19
`define RPSEL_SEL_VSS       5'h1F
`define RPSEL_OUT_NULL      5'h00
`define RPSEL_OUT_UTX       5'h03
`define RPSEL_OUT_URTS      5'h04
// unlock keys for the oscillator control low byte
`define RPSEL_KEY1          8'h46
`define RPSEL_KEY2          8'h57
`define RPSEL_ZERO16        16'h0000

`endif

//--- design/rpsel_in_mux.v
// Purpose: one peripheral input multiplexer indexed by a 5-bit field
// Assumes: pins already synchronised by the caller
// Notes:   codes above the last pin and the tie code give a low level
`timescale 1ns/1ns
`include "rpsel_consts.vh"

module rpsel_in_mux (
   input  wire [`RPSEL_NPIN-1:0] i_pins,
   input  wire [`RPSEL_SELW-1:0] i_sel,
   output wire                   o_in
);

   // unused codes 11010..11110 also read low, a safe quiet input
   assign o_in = (i_sel <= `RPSEL_SEL_MAXPIN) ? i_pins[i_sel] : 1'b0;

endmodule // rpsel_in_mux

//--- design/rpsel_top.v
// Purpose: remappable pin select, input maps for irq and timer clocks
// Assumes: 20 MHz system clock, synchronous active-low reset
// Notes:   register port, read data one cycle after the read strobe
//          only the irq and timer-clock input maps and four output pins exist here
//          pins are filtered before routing, so a routed level lags its pin
//          by about five clocks; software sees none of that delay in the maps
`timescale 1ns/1ns
`include "rpsel_consts.vh"

module rpsel_top (
   input  wire                   i_clk_sys,
   input  wire                   i_rstn,
   input  wire                   i_ce,
   input  wire [`RPSEL_AW-1:0]   i_addr,
   input  wire [`RPSEL_DW-1:0]   i_wdata,
   input  wire                   i_wr,
   input  wire                   i_rd,
   output reg  [`RPSEL_DW-1:0]   o_rdata,
   input  wire                   i_one_way_lock_cfg,
   input  wire [`RPSEL_NPIN-1:0] i_remappable_pin,
   input  wire [`RPSEL_NPIN-1:0] i_pin_analog,
   input  wire                   i_uart_transmit_out,
   input  wire                   i_uart_request_to_send_out,
   output reg                    o_external_irq_one,
   output reg                    o_external_irq_two,
   output reg                    o_timer2_ext_clock,
   output reg                    o_timer3_ext_clock,
   output reg  [3:0]             o_pin_out,
   output reg  [3:0]             o_pin_out_en,
   output wire                   o_map_write_lock
);

   // storage: three of the nine input maps and two of the eight output maps
   // are built here; the rest of the map space reads zero like a hole, so
   // software written for the full map set still runs without faults
   reg  [`RPSEL_SELW-1:0] ext_irq1_pin_sel_reg;
   reg  [`RPSEL_SELW-1:0] ext_irq2_pin_sel_reg;
   reg  [`RPSEL_SELW-1:0] timer2_clk_pin_sel_reg;
   reg  [`RPSEL_SELW-1:0] timer3_clk_pin_sel_reg;
   reg  [`RPSEL_SELW-1:0] out_sel_reg [0:3];
   reg                    map_write_lock_reg;
   reg                    was_locked_reg;
   reg  [1:0]             key_state_reg;
   reg  [`RPSEL_NPIN-1:0] pin_s1_reg;
   reg  [`RPSEL_NPIN-1:0] pin_s2_reg;
   reg  [`RPSEL_NPIN-1:0] pin_s3_reg;
   reg  [`RPSEL_NPIN-1:0] pin_db_reg;
   wire [`RPSEL_NPIN-1:0] pin_dig;
   wire                   irq1_mux;
   wire                   irq2_mux;
   wire                   t2_mux;
   wire                   t3_mux;
   wire                   map_wr_ok;
   wire [3:0]             pin_out_next;
   wire [3:0]             pin_en_next;
   integer                k;

   // key sequence states; only the write right after both keys may move
   // the lock, any other byte written to the oscillator control register in between starts the sequence again
   localparam [1:0] KEY_IDLE = 2'b00;
   localparam [1:0] KEY_ONE  = 2'b01;
   localparam [1:0] KEY_OPEN = 2'b10;

   // decode helper, shared by write and read paths; keeping one compare
   // means the write and read maps can never drift apart
   function is_addr;
      input [`RPSEL_AW-1:0] a;
      input [`RPSEL_AW-1:0] off;
      begin
         is_addr = (a == off);
      end
   endfunction

   // pins come from outside: three stages, change taken when 2nd and 3rd agree
   // a glitch seen in one stage only never reaches a peripheral; the price
   // is two extra clocks of delay on every routed interrupt or clock edge
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         pin_s1_reg <= {`RPSEL_NPIN{1'b0}};
         pin_s2_reg <= {`RPSEL_NPIN{1'b0}};
         pin_s3_reg <= {`RPSEL_NPIN{1'b0}};
         pin_db_reg <= {`RPSEL_NPIN{1'b0}};
      end else if (i_ce) begin
         pin_s1_reg <= i_remappable_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (k = 0; k < `RPSEL_NPIN; k = k + 1) begin
            if (pin_s2_reg[k] == pin_s3_reg[k]) begin
               pin_db_reg[k] <= pin_s3_reg[k];
            end
         end
      end
   end

   // analog pins feed nothing digital; no pin setting is changed here
   assign pin_dig = pin_db_reg & ~i_pin_analog;

   // one mux per peripheral input, pins may be shared freely
   // several peripherals may point at one pin; nothing arbitrates between them
   rpsel_in_mux u_mux_irq1 (
      .i_pins (pin_dig),
      .i_sel  (ext_irq1_pin_sel_reg),
      .o_in   (irq1_mux)
   );
   rpsel_in_mux u_mux_irq2 (
      .i_pins (pin_dig),
      .i_sel  (ext_irq2_pin_sel_reg),
      .o_in   (irq2_mux)
   );
   rpsel_in_mux u_mux_t2 (
      .i_pins (pin_dig),
      .i_sel  (timer2_clk_pin_sel_reg),
      .o_in   (t2_mux)
   );
   rpsel_in_mux u_mux_t3 (
      .i_pins (pin_dig),
      .i_sel  (timer3_clk_pin_sel_reg),
      .o_in   (t3_mux)
   );

   // routed level only; the peripheral still needs its own enable
   // registering here keeps the mux decode glitches away from edge detectors
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_external_irq_one <= 1'b0;
         o_external_irq_two <= 1'b0;
         o_timer2_ext_clock <= 1'b0;
         o_timer3_ext_clock <= 1'b0;
      end else if (i_ce) begin
         o_external_irq_one <= irq1_mux;
         o_external_irq_two <= irq2_mux;
         o_timer2_ext_clock <= t2_mux;
         o_timer3_ext_clock <= t3_mux;
      end
   end

   // lock key sequence on the oscillator control low byte
   // a stray byte between the keys, other than a repeated first key, drops back to idle, so a runaway loop
   // writing this register cannot unlock the maps by accident
   // the ever-locked memory is cleared only by reset, which is what makes
   // the one-way option hold across any number of key sequences
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         key_state_reg      <= KEY_IDLE;
         map_write_lock_reg <= 1'b0;
         was_locked_reg     <= 1'b0;
      end else if (i_ce && i_wr && is_addr(i_addr, `RPSEL_OFF_OSC)) begin
         case (key_state_reg)
            KEY_IDLE: begin
               if (i_wdata[7:0] == `RPSEL_KEY1) begin
                  key_state_reg <= KEY_ONE;
               end
            end
            KEY_ONE: begin
               if (i_wdata[7:0] == `RPSEL_KEY2) begin
                  key_state_reg <= KEY_OPEN;
               end else if (i_wdata[7:0] != `RPSEL_KEY1) begin
                  key_state_reg <= KEY_IDLE;
               end
            end
            KEY_OPEN: begin
               key_state_reg <= KEY_IDLE;
               // one-way option: once set, the lock can never fall again
               if (i_wdata[`RPSEL_LOCK_BIT]) begin
                  map_write_lock_reg <= 1'b1;
                  was_locked_reg     <= 1'b1;
               end else if (!(i_one_way_lock_cfg && was_locked_reg)) begin
                  map_write_lock_reg <= 1'b0;
               end
            end
            default: key_state_reg <= KEY_IDLE;
         endcase
      end
   end

   assign o_map_write_lock = map_write_lock_reg;
   // locked writes still complete, they just store nothing
   // the bus never stalls, so software cannot tell a locked write apart
   // except by reading the map back
   assign map_wr_ok = i_ce && i_wr && !map_write_lock_reg;

   // mapping registers, only the 5-bit fields exist
   // a write to a hole or to the lock register changes no map
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ext_irq1_pin_sel_reg   <= `RPSEL_SEL_RST;
         ext_irq2_pin_sel_reg   <= `RPSEL_SEL_RST;
         timer2_clk_pin_sel_reg <= `RPSEL_SEL_RST;
         timer3_clk_pin_sel_reg <= `RPSEL_SEL_RST;
         out_sel_reg[0]         <= `RPSEL_OUT_NULL;
         out_sel_reg[1]         <= `RPSEL_OUT_NULL;
         out_sel_reg[2]         <= `RPSEL_OUT_NULL;
         out_sel_reg[3]         <= `RPSEL_OUT_NULL;
      end else if (map_wr_ok) begin
         if (is_addr(i_addr, `RPSEL_OFF_IRQ1)) begin
            ext_irq1_pin_sel_reg <= i_wdata[`RPSEL_HI_LSB +: `RPSEL_SELW];
         end else if (is_addr(i_addr, `RPSEL_OFF_IRQ2)) begin
            ext_irq2_pin_sel_reg <= i_wdata[`RPSEL_LO_LSB +: `RPSEL_SELW];
         end else if (is_addr(i_addr, `RPSEL_OFF_TMR)) begin
            timer3_clk_pin_sel_reg <= i_wdata[`RPSEL_HI_LSB +: `RPSEL_SELW];
            timer2_clk_pin_sel_reg <= i_wdata[`RPSEL_LO_LSB +: `RPSEL_SELW];
         end else if (is_addr(i_addr, `RPSEL_OFF_OUTMAP0)) begin
            out_sel_reg[0] <= i_wdata[`RPSEL_LO_LSB +: `RPSEL_SELW];
            out_sel_reg[1] <= i_wdata[`RPSEL_HI_LSB +: `RPSEL_SELW];
         end else if (is_addr(i_addr, `RPSEL_OFF_OUTMAP1)) begin
            out_sel_reg[2] <= i_wdata[`RPSEL_LO_LSB +: `RPSEL_SELW];
            out_sel_reg[3] <= i_wdata[`RPSEL_HI_LSB +: `RPSEL_SELW];
         end
      end
   end

   // output selection for pins 0..3; null leaves the default port function
   // codes other than the two uart outputs are not built and drive nothing
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_out
         assign pin_out_next[g] =
            (out_sel_reg[g] == `RPSEL_OUT_UTX)  ? i_uart_transmit_out :
            (out_sel_reg[g] == `RPSEL_OUT_URTS) ? i_uart_request_to_send_out : 1'b0;
         // an analog pin never gets a digital driver
         assign pin_en_next[g] = ~i_pin_analog[g] &
            ((out_sel_reg[g] == `RPSEL_OUT_UTX) | (out_sel_reg[g] == `RPSEL_OUT_URTS));
      end
   endgenerate

   // one process for all four pins keeps a single driver per output
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_pin_out    <= 4'h0;
         o_pin_out_en <= 4'h0;
      end else if (i_ce) begin
         o_pin_out    <= pin_out_next;
         o_pin_out_en <= pin_en_next;
      end
   end

   // read path, empty bits and unmapped addresses read zero
   // reads have no side effects, so software may poll the lock freely;
   // data stands one cycle only while i_ce is high, a late sample then sees zero; with i_ce low it holds
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_rdata <= `RPSEL_ZERO16;
      end else if (i_ce) begin
         o_rdata <= `RPSEL_ZERO16;
         if (i_rd) begin
            if (is_addr(i_addr, `RPSEL_OFF_IRQ1)) begin
               o_rdata[`RPSEL_HI_LSB +: `RPSEL_SELW] <= ext_irq1_pin_sel_reg;
            end else if (is_addr(i_addr, `RPSEL_OFF_IRQ2)) begin
               o_rdata[`RPSEL_LO_LSB +: `RPSEL_SELW] <= ext_irq2_pin_sel_reg;
            end else if (is_addr(i_addr, `RPSEL_OFF_TMR)) begin
               o_rdata[`RPSEL_HI_LSB +: `RPSEL_SELW] <= timer3_clk_pin_sel_reg;
               o_rdata[`RPSEL_LO_LSB +: `RPSEL_SELW] <= timer2_clk_pin_sel_reg;
            end else if (is_addr(i_addr, `RPSEL_OFF_OSC)) begin
               o_rdata[`RPSEL_LOCK_BIT] <= map_write_lock_reg;
            end else if (is_addr(i_addr, `RPSEL_OFF_OUTMAP0)) begin
               o_rdata[`RPSEL_LO_LSB +: `RPSEL_SELW] <= out_sel_reg[0];
               o_rdata[`RPSEL_HI_LSB +: `RPSEL_SELW] <= out_sel_reg[1];
            end else if (is_addr(i_addr, `RPSEL_OFF_OUTMAP1)) begin
               o_rdata[`RPSEL_LO_LSB +: `RPSEL_SELW] <= out_sel_reg[2];
               o_rdata[`RPSEL_HI_LSB +: `RPSEL_SELW] <= out_sel_reg[3];
            end
         end
      end
   end

endmodule // rpsel_top

//--- verif/rpsel_monitor.sv
// Purpose: port checker for the pin select block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the top, sees its ports only
`timescale 1ns/1ns
`include "rpsel_consts.vh"
module rpsel_monitor (
   input logic                 i_clk_sys,
   input logic                 i_rstn,
   input logic                 i_ce,
   input logic [`RPSEL_AW-1:0] i_addr,
   input logic                 i_wr,
   input logic                 i_rd,
   input logic                 i_one_way_lock_cfg,
   input logic [`RPSEL_DW-1:0] o_rdata,
   input logic [3:0]           o_pin_out_en,
   input logic                 o_map_write_lock
);
   logic rd_q;
   logic wr_osc;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // taken read, taken lock-register write
   assign rd_q = i_rd && i_ce;
   assign wr_osc = i_wr && i_ce && i_addr == `RPSEL_OFF_OSC;
   // unused bits of a field register read back as zero
   property zero_bits(a, m);
      $past(rd_q) && $past(i_addr) == a |-> (o_rdata & m) == 16'h0000;
   endproperty
   rst_clear_a: assert property (disable iff (1'b0) !i_rstn |=> o_rdata == 16'h0000
      && !o_map_write_lock && o_pin_out_en == 4'h0) else $error("state kept over reset");
   rd_idle_a: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside its cycle");
   irq1_bits_a: assert property (zero_bits(`RPSEL_OFF_IRQ1, 16'hE0FF))
      else $error("irq1 register loose bits set");
   irq2_bits_a: assert property (zero_bits(`RPSEL_OFF_IRQ2, 16'hFFE0))
      else $error("irq2 register loose bits set");
   timer_bits_a: assert property (zero_bits(`RPSEL_OFF_TMR, 16'hE0E0))
      else $error("timer register loose bits set");
   unmapped_zero_a: assert property (zero_bits(4'h2, 16'hFFFF))
      else $error("unmapped read not zero");
   lock_cause_a: assert property ($changed(o_map_write_lock) |-> $past(wr_osc)
      || $past(wr_osc, 2)) else $error("lock moved without a write");
   one_way_a: assert property (o_map_write_lock && i_one_way_lock_cfg |=> o_map_write_lock)
      else $error("one-way lock was cleared");
   cover property ($rose(o_map_write_lock));
   cover property (rd_q && i_addr == `RPSEL_OFF_TMR);
   cover property (o_pin_out_en != 4'h0);
endmodule // rpsel_monitor

//--- verif/rpsel_pins.sv
// Purpose: pin levels and uart outputs outside the block
// Assumes: levels move just after a clock edge
// Notes:   request-to-send is kept opposite to transmit
`timescale 1ns/1ns
module rpsel_pins (
   input  logic        i_clk_sys,
   input  logic [25:0] i_lvl,
   input  logic        i_tx,
   output logic [25:0] o_pins,
   output logic        o_tx,
   output logic        o_rts
);
   // registered so levels never change on the sampling edge
   always @(posedge i_clk_sys) begin
      o_pins <= i_lvl;
      o_tx <= i_tx;
      o_rts <= ~i_tx;
   end
endmodule // rpsel_pins

//--- verif/tb_rpsel_top.sv
// Purpose: self-checking bench for the pin select block
// Assumes: 20 MHz clock, reset held six cycles
// Notes:   expected reads come from a masked register model
`timescale 1ns/1ns
`include "rpsel_consts.vh"
module tb_rpsel_top;
   logic i_clk_sys, i_rstn, i_ce, i_wr, i_rd, i_one_way_lock_cfg, tx, utx, urts, lock, e;
   logic [3:0] i_addr, pout, pen, ad[6] = '{4'h0, 4'h1, 4'h3, 4'h9, 4'hA, 4'h2};
   logic [15:0] i_wdata, o_rdata, m[0:15];
   logic [25:0] lvl, pins, ana;
   logic [4:0] c, cs[5] = '{5'h00, 5'h09, 5'h19, 5'h1A, 5'h1F};
   logic irq1, irq2, t2, t3;
   integer n_mismatch, comparisons, k, lk;
   rpsel_top i_rpsel_top (.i_clk_sys, .i_rstn, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_one_way_lock_cfg, .i_remappable_pin(pins), .i_pin_analog(ana),
      .i_uart_transmit_out(utx), .i_uart_request_to_send_out(urts), .o_external_irq_one(irq1),
      .o_external_irq_two(irq2), .o_timer2_ext_clock(t2), .o_timer3_ext_clock(t3),
      .o_pin_out(pout), .o_pin_out_en(pen), .o_map_write_lock(lock));
   rpsel_pins i_rpsel_pins (.i_clk_sys, .i_lvl(lvl), .i_tx(tx), .o_pins(pins), .o_tx(utx),
      .o_rts(urts));
   function automatic logic [15:0] msk(input logic [3:0] a);
      case (a)
         4'h0: msk = 16'h1F00;
         4'h1: msk = 16'h001F;
         4'h3, 4'h9, 4'hA: msk = 16'h1F1F;
         default: msk = 16'h0000;
      endcase
   endfunction
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // a locked write leaves the model alone too
   task wr(input logic [3:0] a, input logic [15:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
      if (lk == 0) m[a] = d & msk(a);
   endtask
   task rd(input logic [3:0] a);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      #1 chk("o_rdata", o_rdata, m[a]);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task key(input logic [15:0] d);
      wr(4'h8, 16'h0046);
      wr(4'h8, 16'h0057);
      wr(4'h8, d);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // watchdog against a hung sequence
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      n_mismatch = n_mismatch + 1;
      final_report;
   end
   initial begin
      {i_rstn, i_wr, i_rd, i_one_way_lock_cfg, tx, i_addr, i_wdata, lvl, ana} = '0;
      {n_mismatch, comparisons, lk} = '0;
      i_ce = 1'b1;
      for (k = 0; k < 16; k++) m[k] = 16'h0000;
      void'($urandom(32'h929C));
      repeat (6) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      for (k = 0; k < 6; k++) rd(ad[k]);
      chk("lock", {15'h0, lock}, 16'h0000);
      wr(4'h8, 16'h0040);
      chk("lock", {15'h0, lock}, 16'h0000);
      // all ones first, then random words, into every map and a hole
      for (k = 0; k < 12; k++) begin
         wr(ad[k % 6], (k < 6) ? 16'hFFFF : 16'($urandom));
         rd(ad[k % 6]);
      end
      // all four inputs share one pin; last pass makes it analog
      for (k = 0; k < 6; k++) begin
         c = (k < 5) ? cs[k] : 5'h09;
         lvl <= 26'($urandom);
         ana <= (k == 5) ? 26'h0000200 : 26'h0;
         wr(4'h0, {3'b0, c, 8'h00});
         wr(4'h1, {11'h0, c});
         wr(4'h3, {3'b0, c, 3'b0, c});
         repeat (8) @(posedge i_clk_sys);
         e = (c < 5'h1A && k < 5) ? lvl[c] : 1'b0;
         chk("routed inputs", {12'h0, irq1, irq2, t2, t3}, {12'h0, {4{e}}});
      end
      wr(4'h9, 16'h0403);
      wr(4'hA, 16'h0000);
      for (k = 0; k < 3; k++) begin
         tx <= k[0];
         ana <= (k == 2) ? 26'h1 : 26'h0;
         repeat (8) @(posedge i_clk_sys);
         chk("pin_out_en", {12'h0, pen}, (k == 2) ? 16'h0002 : 16'h0003);
         chk("pin_out", {14'h0, pout[1], pout[0] & pen[0]}, {14'h0, ~k[0], k[0]});
      end
      key(16'h0040);
      lk = 1;
      chk("lock", {15'h0, lock}, 16'h0001);
      wr(4'h0, 16'h1500);
      rd(4'h0);
      key(16'h0000);
      lk = 0;
      wr(4'h0, 16'h1500);
      rd(4'h0);
      // a write while the clock enable is low must not land
      i_ce <= 1'b0;
      lk = 1;
      wr(4'h3, 16'h0101);
      i_ce <= 1'b1;
      lk = 0;
      rd(4'h3);
      i_one_way_lock_cfg <= 1'b1;
      key(16'h0040);
      key(16'h0000);
      lk = 1;
      chk("lock", {15'h0, lock}, 16'h0001);
      wr(4'h1, 16'h0007);
      rd(4'h1);
      final_report;
   end
endmodule // tb_rpsel_top
bind rpsel_top rpsel_monitor i_mon (.i_clk_sys, .i_rstn, .i_ce, .i_addr, .i_wr, .i_rd,
   .i_one_way_lock_cfg, .o_rdata, .o_pin_out_en, .o_map_write_lock);
